// File: design/common_command_status.sv
`default_nettype none
module common_command_status
    import status_model_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               resetn,
    input  wire logic               cmd_valid,
    input  wire logic [IFACE_W-1:0] cmd_iface,
    input  wire logic [3:0]         cmd_code,
    input  wire logic [7:0]         cmd_arg,
    input  wire logic               cmd_malformed,
    input  wire logic               query_err,
    input  wire logic               dev_err,
    input  wire logic [NUM_IFACE-1:0] oper_summary,
    input  wire logic [RELAY_W-1:0] relay_state,
    input  wire logic               options_present,
    input  wire logic               nv_busy,
    input  wire logic               nv_fail,
    input  wire logic [RELAY_W-1:0] nv_rdata,
    output logic                    reply_valid,
    output logic [IFACE_W-1:0]      reply_iface,
    output logic [7:0]              reply_data,
    output logic                    nv_write,
    output logic                    nv_read,
    output logic [RELAY_W-1:0]      nv_wdata,
    output logic                    relay_load,
    output logic [RELAY_W-1:0]      relay_wdata,
    output logic                    trigger_pulse,
    output logic                    reset_pulse
);

    ////////////////////////////////////////////////////////////////////////
    // Command decode

    // One-hot select of the addressed interface
    function automatic logic [NUM_IFACE-1:0] iface_sel(input logic [IFACE_W-1:0] idx);
        iface_sel = '0;
        iface_sel[idx] = 1'b1;
    endfunction

    logic                 go;
    logic                 is_err;
    logic [NUM_IFACE-1:0] hit;
    cmd_e                 cmd;

    assign cmd    = cmd_e'(cmd_code);
    assign go     = cmd_valid && !cmd_malformed;
    assign is_err = cmd_valid && cmd_malformed;
    assign hit    = iface_sel(cmd_iface);

    ////////////////////////////////////////////////////////////////////////
    // Per-interface status sets

    logic [7:0] ev_w   [NUM_IFACE];
    logic [7:0] ese_w  [NUM_IFACE];
    logic [7:0] sre_w  [NUM_IFACE];
    logic [7:0] sb_w   [NUM_IFACE];
    logic       exec_err_p;
    logic                 nv_write_q;
    logic                 nv_read_q;
    logic [RELAY_W-1:0]   nv_wdata_q;
    logic [IFACE_W-1:0]   nv_iface_q;
    logic                 relay_load_q;
    logic [RELAY_W-1:0]   relay_wdata_q;
    logic                 trigger_q;
    logic                 reset_q;
    logic                 do_sav;
    logic                 do_rcl;

    // Save fails on storage error
    assign exec_err_p = nv_write_q && nv_fail;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IFACE; gi++) begin : g_iface
            iface_status_regs u_regs (
                .clk_sys      (clk_sys),
                .resetn       (resetn),
                .set_cmd_err  (is_err && hit[gi]),
                .set_exec_err (exec_err_p && (nv_iface_q == IFACE_W'(gi))),
                .set_dev_err  (dev_err),
                .set_query_err(query_err && hit[gi]),
                .set_op_done  (go && hit[gi] && cmd == CMD_OPC_SET),
                .clear_events (go && hit[gi] && cmd == CMD_CLS),
                .read_clear   (go && hit[gi] && cmd == CMD_ESR_GET),
                .load_ese     (go && hit[gi] && cmd == CMD_ESE_SET),
                .load_sre     (go && hit[gi] && cmd == CMD_SRE_SET),
                .wdata        (cmd_arg),
                .oper_summary (oper_summary[gi]),
                .events       (ev_w[gi]),
                .ese          (ese_w[gi]),
                .sre          (sre_w[gi]),
                .status_byte  (sb_w[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Reply selection

    logic       is_query;
    logic [7:0] reply_d;

    assign is_query = go && (cmd inside {CMD_IDN, CMD_TST, CMD_ESE_GET, CMD_ESR_GET, CMD_SRE_GET,
                                         CMD_STB_GET, CMD_OPC_GET, CMD_OPT_GET});

    always_comb begin
        unique case (cmd)
            CMD_IDN:     reply_d = IDENT_CODE;
            CMD_TST:     reply_d = TEST_PASS;
            CMD_ESE_GET: reply_d = ese_w[cmd_iface];
            CMD_ESR_GET: reply_d = ev_w[cmd_iface];
            CMD_SRE_GET: reply_d = sre_w[cmd_iface];
            CMD_STB_GET: reply_d = sb_w[cmd_iface];
            CMD_OPC_GET: reply_d = OPC_REPLY;
            CMD_OPT_GET: reply_d = {7'b000_0000, options_present};
            default:     reply_d = 8'h00;
        endcase
    end

    logic                 reply_valid_q;
    logic [IFACE_W-1:0]   reply_iface_q;
    logic [7:0]           reply_data_q;

    // Registered reply, one cycle after the command
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reply_valid_q <= 1'b0;
            reply_iface_q <= '0;
            reply_data_q  <= 8'h00;
        end else begin
            reply_valid_q <= is_query;
            reply_iface_q <= cmd_iface;
            reply_data_q  <= is_query ? reply_d : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage, trigger and reset actions

    // Save and recall go ahead only while storage is idle
    assign do_sav = go && cmd == CMD_SAV && !nv_busy;
    assign do_rcl = go && cmd == CMD_RCL && !nv_busy;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            nv_write_q    <= 1'b0;
            nv_read_q     <= 1'b0;
            nv_wdata_q    <= '0;
            nv_iface_q    <= '0;
            relay_load_q  <= 1'b0;
            relay_wdata_q <= '0;
            trigger_q     <= 1'b0;
            reset_q       <= 1'b0;
        end else begin
            nv_write_q   <= do_sav;
            nv_read_q    <= do_rcl;
            relay_load_q <= nv_read_q;
            trigger_q    <= go && cmd == CMD_TRG;
            reset_q      <= go && cmd == CMD_RST;
            if (do_sav || do_rcl) begin
                nv_iface_q <= cmd_iface;
            end
            if (do_sav) begin
                nv_wdata_q <= relay_state;
            end
            if (nv_read_q) begin
                relay_wdata_q <= nv_rdata;
            end
        end
    end

    assign reply_valid   = reply_valid_q;
    assign reply_iface   = reply_iface_q;
    assign reply_data    = reply_data_q;
    assign nv_write      = nv_write_q;
    assign nv_read       = nv_read_q;
    assign nv_wdata      = nv_wdata_q;
    assign relay_load    = relay_load_q;
    assign relay_wdata   = relay_wdata_q;
    assign trigger_pulse = trigger_q;
    assign reset_pulse   = reset_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_err_cmd;
        is_err && cmd_iface == 2'd0;
    endsequence

    chk_power_on_set: assert property (@(posedge clk_sys) $rose(resetn) |-> ev_w[0][EV_POWER_ON])
        else $error("power-on flag missing after reset");
    chk_user_req_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        ev_w[1][EV_USER_REQ] == 1'b0) else $error("user request flag set");
    chk_cmd_err_local: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_err_cmd |=> ev_w[0][EV_CMD_ERR] && $stable(ev_w[1][EV_CMD_ERR])) else $error("command error misrouted");
    chk_opc_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
        go && cmd == CMD_OPC_SET && cmd_iface == 2'd2 |=> ev_w[2][EV_OP_DONE]) else $error("op complete flag not set");
    chk_opc_reply: assert property (@(posedge clk_sys) disable iff (!resetn)
        go && cmd == CMD_OPC_GET |=> reply_valid && reply_data == 8'h01) else $error("op complete reply wrong");
    chk_esr_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        go && cmd == CMD_ESR_GET && cmd_iface == 2'd1 && !query_err && !dev_err
        |=> reply_data == $past(ev_w[1]) && ev_w[1] == 8'h00) else $error("event read not cleared");
    chk_ev_summary: assert property (@(posedge clk_sys) disable iff (!resetn)
        sb_w[3][SB_EV_SUM] == |(ev_w[3] & ese_w[3])) else $error("event summary wrong");
    chk_master_sum: assert property (@(posedge clk_sys) disable iff (!resetn)
        sb_w[0][SB_MASTER] == |(sb_w[0] & sre_w[0] & 8'hBF)) else $error("master summary wrong");
    chk_save_data: assert property (@(posedge clk_sys) disable iff (!resetn)
        do_sav |=> nv_write && nv_wdata == $past(relay_state)) else $error("save data wrong");

    ////////////////////////////////////////////////////////////////////////
    // Command steps and further checks

    // Accepted and malformed commands by kind
    sequence s_query_taken;
        is_query;
    endsequence

    sequence s_bad_taken;
        is_err;
    endsequence

    sequence s_sav_taken;
        do_sav;
    endsequence

    sequence s_rcl_taken;
        do_rcl;
    endsequence

    sequence s_trg_taken;
        go && cmd == CMD_TRG;
    endsequence

    sequence s_rst_taken;
        go && cmd == CMD_RST;
    endsequence

    // Recall: storage read strobe one cycle after the command
    sequence s_rcl_read;
        s_rcl_taken ##1 nv_read;
    endsequence

    // Replies: timing, source and idle level
    chk_reply_follows: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_query_taken |=> reply_valid && reply_iface == $past(cmd_iface)) else $error("reply missing");
    chk_reply_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
        !is_query |=> !reply_valid && reply_data == 8'h00) else $error("reply without query");
    chk_bad_no_reply: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_bad_taken |=> !reply_valid) else $error("reply to malformed command");

    // Fixed and register replies
    chk_idn_reply: assert property (@(posedge clk_sys) disable iff (!resetn)
        go && cmd == CMD_IDN |=> reply_data == IDENT_CODE) else $error("ident reply wrong");
    chk_tst_reply: assert property (@(posedge clk_sys) disable iff (!resetn)
        go && cmd == CMD_TST |=> reply_data == TEST_PASS) else $error("self test reply wrong");
    chk_opt_reply: assert property (@(posedge clk_sys) disable iff (!resetn)
        go && cmd == CMD_OPT_GET |=> reply_data == {7'b000_0000, $past(options_present)}) else $error("option reply wrong");
    chk_ese_reply: assert property (@(posedge clk_sys) disable iff (!resetn)
        go && cmd == CMD_ESE_GET |=> reply_data == $past(ese_w[cmd_iface])) else $error("event mask reply wrong");
    chk_sre_reply: assert property (@(posedge clk_sys) disable iff (!resetn)
        go && cmd == CMD_SRE_GET |=> reply_data == $past(sre_w[cmd_iface])) else $error("service mask reply wrong");
    chk_stb_reply: assert property (@(posedge clk_sys) disable iff (!resetn)
        go && cmd == CMD_STB_GET |=> reply_data == $past(sb_w[cmd_iface])) else $error("status byte reply wrong");

    // Mask loads on the bus interface set
    chk_ese_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        go && cmd == CMD_ESE_SET && cmd_iface == 2'd0 |=> ese_w[0] == $past(cmd_arg)) else $error("event mask not loaded");
    chk_ese_keep: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(go && cmd == CMD_ESE_SET && cmd_iface == 2'd0) |=> $stable(ese_w[0])) else $error("event mask changed");
    chk_sre_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        go && cmd == CMD_SRE_SET && cmd_iface == 2'd0 |=> sre_w[0] == $past(cmd_arg)) else $error("service mask not loaded");

    // Storage strobes
    chk_sav_iface: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_sav_taken |=> nv_write && nv_iface_q == $past(cmd_iface)) else $error("save strobe wrong");
    chk_busy_refused: assert property (@(posedge clk_sys) disable iff (!resetn)
        go && nv_busy && (cmd == CMD_SAV || cmd == CMD_RCL) |=> !nv_write && !nv_read) else $error("busy not obeyed");
    chk_no_sav_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        !do_sav |=> !nv_write) else $error("stray storage write");
    chk_recall_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_rcl_read |=> relay_load && relay_wdata == $past(nv_rdata)) else $error("recall load wrong");
    chk_load_only_rcl: assert property (@(posedge clk_sys) disable iff (!resetn)
        !nv_read |=> !relay_load) else $error("stray relay load");

    // Trigger and reset pulses
    chk_trg_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_trg_taken |=> trigger_pulse) else $error("trigger pulse missing");
    chk_trg_only: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(go && cmd == CMD_TRG) |=> !trigger_pulse) else $error("stray trigger pulse");
    chk_rst_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_rst_taken |=> reset_pulse) else $error("reset pulse missing");
    chk_rst_only: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(go && cmd == CMD_RST) |=> !reset_pulse) else $error("stray reset pulse");

    // Event flags and status byte bits across the sets
    chk_exec_err_set: assert property (@(posedge clk_sys) disable iff (!resetn)
        nv_write && nv_fail && nv_iface_q == 2'd0 |=> ev_w[0][EV_EXEC_ERR]) else $error("execution error missing");
    chk_dev_err_all: assert property (@(posedge clk_sys) disable iff (!resetn)
        dev_err |=> ev_w[0][EV_DEV_ERR] && ev_w[3][EV_DEV_ERR]) else $error("device error missing");
    chk_query_err_own: assert property (@(posedge clk_sys) disable iff (!resetn)
        query_err && cmd_iface == 2'd2 |=> ev_w[2][EV_QUERY_ERR]) else $error("query error missing");
    chk_req_ctrl_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        !ev_w[2][EV_REQ_CTRL]) else $error("request control flag set");
    chk_user_req_all: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(ev_w[0][EV_USER_REQ] || ev_w[2][EV_USER_REQ] || ev_w[3][EV_USER_REQ])) else $error("user request flag set");
    chk_cls_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        go && cmd == CMD_CLS && cmd_iface == 2'd0 && !dev_err && !query_err && !nv_fail
        |=> ev_w[0] == 8'h00 && ese_w[0] == $past(ese_w[0])) else $error("clear status wrong");
    chk_cmd_err_set: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_bad_taken and cmd_iface == 2'd1 |=> ev_w[1][EV_CMD_ERR]) else $error("command error missing");
    chk_esr_local: assert property (@(posedge clk_sys) disable iff (!resetn)
        go && cmd == CMD_ESR_GET && cmd_iface == 2'd1 && !dev_err && !nv_fail
        |=> $stable(ev_w[0])) else $error("event read touched other set");
    chk_sb_oper: assert property (@(posedge clk_sys) disable iff (!resetn)
        sb_w[1][SB_OPER] == oper_summary[1]) else $error("operation summary bit wrong");
    chk_sb_unused: assert property (@(posedge clk_sys) disable iff (!resetn)
        sb_w[2][4:0] == 5'b0_0000) else $error("unused status bits set");

endmodule
`default_nettype wire

// File: design/iface_status_regs.sv
`default_nettype none
module iface_status_regs
    import status_model_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       set_cmd_err,
    input  wire logic       set_exec_err,
    input  wire logic       set_dev_err,
    input  wire logic       set_query_err,
    input  wire logic       set_op_done,
    input  wire logic       clear_events,
    input  wire logic       read_clear,
    input  wire logic       load_ese,
    input  wire logic       load_sre,
    input  wire logic [7:0] wdata,
    input  wire logic       oper_summary,
    output logic      [7:0] events,
    output logic      [7:0] ese,
    output logic      [7:0] sre,
    output logic      [7:0] status_byte
);

    logic [7:0] events_q;
    logic [7:0] events_d;
    logic [7:0] set_vec;
    logic [7:0] ese_q;
    logic [7:0] sre_q;
    logic       ev_sum;
    logic [7:0] sb_low;

    // Flags that hardware raises this cycle
    assign set_vec = {1'b0, 1'b0, set_cmd_err, set_exec_err, set_dev_err,
                      set_query_err, 1'b0, set_op_done};
    // Set beats clear; user and control bits forced zero
    assign events_d = ((read_clear || clear_events) ? 8'h00 : events_q) | set_vec;

    // Summaries
    assign ev_sum = |(events_q & ese_q);
    assign sb_low = {oper_summary, 1'b0, ev_sum, 5'b0_0000};

    // Event, enable and service masks
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            events_q <= EVENT_RESET;
            ese_q    <= MASK_RESET;
            sre_q    <= MASK_RESET;
        end else begin
            events_q <= events_d;
            if (load_ese) begin
                ese_q <= wdata;
            end
            if (load_sre) begin
                sre_q <= wdata;
            end
        end
    end

    assign events      = events_q;
    assign ese         = ese_q;
    assign sre         = sre_q;
    assign status_byte = sb_low | {1'b0, |(sb_low & sre_q & 8'hBF), 6'b00_0000};

endmodule
`default_nettype wire

// File: inc/status_model_pkg.sv
`default_nettype none
package status_model_pkg;

    // Interface instances: 0 bus, 1 usb, 2..3 network sessions
    localparam int unsigned NUM_IFACE = 4;
    localparam int unsigned IFACE_W   = 2;
    localparam int unsigned RELAY_W   = 16;

    // Event flag positions
    localparam int unsigned EV_POWER_ON  = 7;
    localparam int unsigned EV_USER_REQ  = 6;
    localparam int unsigned EV_CMD_ERR   = 5;
    localparam int unsigned EV_EXEC_ERR  = 4;
    localparam int unsigned EV_DEV_ERR   = 3;
    localparam int unsigned EV_QUERY_ERR = 2;
    localparam int unsigned EV_REQ_CTRL  = 1;
    localparam int unsigned EV_OP_DONE   = 0;

    // Status byte positions
    localparam int unsigned SB_OPER     = 7;
    localparam int unsigned SB_MASTER   = 6;
    localparam int unsigned SB_EV_SUM   = 5;

    // Reset values and fixed reply codes
    localparam logic [7:0] EVENT_RESET  = 8'h80;
    localparam logic [7:0] MASK_RESET   = 8'h00;
    localparam logic [7:0] OPC_REPLY    = 8'h01;
    localparam logic [7:0] TEST_PASS    = 8'h00;
    localparam logic [7:0] IDENT_CODE   = 8'h5A; // Arbitrary value

    // Common command codes
    typedef enum logic [3:0] {
        CMD_IDN, CMD_RST, CMD_TST, CMD_CLS, CMD_ESE_SET, CMD_ESE_GET,
        CMD_ESR_GET, CMD_SRE_SET, CMD_SRE_GET, CMD_STB_GET, CMD_OPC_SET,
        CMD_OPC_GET, CMD_TRG, CMD_SAV, CMD_RCL, CMD_OPT_GET
    } cmd_e;

endpackage
`default_nettype wire

// File: testbench/common_command_status_test.sv
`default_nettype none
module common_command_status_test
    import status_model_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, resetn, cmd_valid, cmd_malformed, query_err, dev_err, options_present;
    logic [IFACE_W-1:0] cmd_iface, reply_iface;
    logic [3:0] cmd_code, oper_summary;
    logic [7:0] cmd_arg, reply_data;
    logic [RELAY_W-1:0] relay_state, nv_rdata, nv_wdata, relay_wdata;
    logic reply_valid, nv_write, nv_read, relay_load, trigger_pulse, reset_pulse;
    logic nv_busy, nv_fail, busy_req, fail_req;
    int miscompares, check_count;

    common_command_status dut (.clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd_iface(cmd_iface), .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_malformed(cmd_malformed),
        .query_err(query_err), .dev_err(dev_err), .oper_summary(oper_summary), .relay_state(relay_state),
        .options_present(options_present), .nv_busy(nv_busy), .nv_fail(nv_fail), .nv_rdata(nv_rdata),
        .reply_valid(reply_valid), .reply_iface(reply_iface), .reply_data(reply_data),
        .nv_write(nv_write), .nv_read(nv_read), .nv_wdata(nv_wdata), .relay_load(relay_load),
        .relay_wdata(relay_wdata), .trigger_pulse(trigger_pulse), .reset_pulse(reset_pulse));

    nv_store_model nv (.clk_sys(clk_sys), .nv_write(nv_write), .nv_read(nv_read), .nv_wdata(nv_wdata),
        .busy_req(busy_req), .fail_req(fail_req), .nv_busy(nv_busy), .nv_fail(nv_fail), .nv_rdata(nv_rdata));

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic complete_run;
        if (miscompares == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One command cycle; returns in the cycle of the registered answer
    task automatic send(input logic [1:0] ifc, input cmd_e code, input logic [7:0] arg, input logic bad);
        @(negedge clk_sys);
        cmd_valid     = 1'b1;
        cmd_iface     = ifc;
        cmd_code      = code;
        cmd_arg       = arg;
        cmd_malformed = bad;
        @(negedge clk_sys);
        cmd_valid     = 1'b0;
        cmd_malformed = 1'b0;
    endtask

    task automatic query(input logic [1:0] ifc, input cmd_e code, input logic [7:0] exp);
        send(ifc, code, 8'h00, 1'b0);
        check("reply_valid", reply_valid, 1'b1);
        check("reply_iface", reply_iface, ifc);
        check("reply_data", reply_data, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic power_on_flags;
        for (int i = 0; i < NUM_IFACE; i++) begin
            query(i[1:0], CMD_ESR_GET, 8'h80);
            query(i[1:0], CMD_ESR_GET, 8'h00);
        end
    endtask

    task automatic cmd_error_isolation;
        send(2'd1, CMD_IDN, 8'h00, 1'b1);
        check("malformed reply", reply_valid, 1'b0);
        query(2'd1, CMD_ESR_GET, 8'h20);
        query(2'd2, CMD_ESR_GET, 8'h00);
        query(2'd0, CMD_ESR_GET, 8'h00);
    endtask

    task automatic op_complete;
        send(2'd2, CMD_OPC_SET, 8'h00, 1'b0);
        query(2'd2, CMD_ESR_GET, 8'h01);
        query(2'd2, CMD_OPC_GET, OPC_REPLY);
    endtask

    task automatic masks_and_summary;
        send(2'd0, CMD_ESE_SET, 8'h21, 1'b0);
        send(2'd0, CMD_SRE_SET, 8'h20, 1'b0);
        query(2'd0, CMD_ESE_GET, 8'h21);
        query(2'd0, CMD_SRE_GET, 8'h20);
        query(2'd0, CMD_STB_GET, 8'h00);
        send(2'd0, CMD_TST, 8'h00, 1'b1);
        query(2'd0, CMD_STB_GET, 8'h60);
        query(2'd3, CMD_STB_GET, 8'h00);
        send(2'd0, CMD_CLS, 8'h00, 1'b0);
        query(2'd0, CMD_STB_GET, 8'h00);
        query(2'd0, CMD_ESE_GET, 8'h21);
        oper_summary = 4'b0001;
        query(2'd0, CMD_STB_GET, 8'h80);
        send(2'd0, CMD_SRE_SET, 8'h80, 1'b0);
        query(2'd0, CMD_STB_GET, 8'hC0);
        oper_summary = 4'b0000;
    endtask

    task automatic fixed_replies;
        query(2'd1, CMD_IDN, IDENT_CODE);
        query(2'd1, CMD_TST, TEST_PASS);
        send(2'd1, CMD_OPT_GET, 8'h00, 1'b0);
        check("option reply", reply_valid, 1'b1);
        check("option none", reply_data, 8'h00);
        options_present = 1'b1;
        send(2'd1, CMD_OPT_GET, 8'h00, 1'b0);
        check("option present", reply_data, 8'h01);
    endtask

    task automatic trigger_and_reset;
        send(2'd3, CMD_TRG, 8'h00, 1'b0);
        check("trigger_pulse", trigger_pulse, 1'b1);
        @(negedge clk_sys);
        check("trigger_pulse end", trigger_pulse, 1'b0);
        send(2'd3, CMD_RST, 8'h00, 1'b0);
        check("reset_pulse", reset_pulse, 1'b1);
    endtask

    task automatic save_recall;
        relay_state = 16'hA5C3;
        send(2'd0, CMD_SAV, 8'h00, 1'b0);
        check("nv_write", nv_write, 1'b1);
        check("nv_wdata", nv_wdata, 16'hA5C3);
        relay_state = 16'h0000;
        busy_req    = 1'b1;
        send(2'd0, CMD_SAV, 8'h00, 1'b0);
        check("busy save", nv_write, 1'b0);
        busy_req = 1'b0;
        send(2'd0, CMD_RCL, 8'h00, 1'b0);
        check("nv_read", nv_read, 1'b1);
        @(negedge clk_sys);
        check("relay_load", relay_load, 1'b1);
        check("relay_wdata", relay_wdata, 16'hA5C3);
        fail_req = 1'b1;
        send(2'd0, CMD_SAV, 8'h00, 1'b0);
        @(negedge clk_sys);
        fail_req = 1'b0;
        query(2'd0, CMD_ESR_GET, 8'h10);
    endtask

    task automatic error_inputs;
        @(negedge clk_sys);
        cmd_iface = 2'd2;
        query_err = 1'b1;
        dev_err   = 1'b1;
        @(negedge clk_sys);
        query_err = 1'b0;
        dev_err   = 1'b0;
        query(2'd2, CMD_ESR_GET, 8'h0C);
        query(2'd1, CMD_ESR_GET, 8'h08);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Cut a hang short
    initial begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        complete_run();
    end

    // Main sequence
    initial begin
        {resetn, cmd_valid, cmd_malformed, query_err, dev_err, options_present} = 6'b0;
        {busy_req, fail_req, cmd_iface, cmd_code, cmd_arg, oper_summary} = '0;
        relay_state = 16'h0000;
        miscompares = 0;
        check_count = 0;
        repeat (16) @(negedge clk_sys);
        resetn = 1'b1;
        power_on_flags();
        cmd_error_isolation();
        op_complete();
        masks_and_summary();
        fixed_replies();
        trigger_and_reset();
        save_recall();
        error_inputs();
        complete_run();
    end
endmodule
`default_nettype wire

// File: testbench/nv_store_model.sv
`default_nettype none
module nv_store_model
    import status_model_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               nv_write,
    input  wire logic               nv_read,
    input  wire logic [RELAY_W-1:0] nv_wdata,
    input  wire logic               busy_req,
    input  wire logic               fail_req,
    output logic                    nv_busy,
    output logic                    nv_fail,
    output logic      [RELAY_W-1:0] nv_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [RELAY_W-1:0] store_q;
    // Keep the image of a save that did not fail
    always_ff @(posedge clk_sys) begin
        if (nv_write && !fail_req) begin
            store_q <= nv_wdata;
        end
    end
    // Data only valid in the read cycle, inverted otherwise
    assign nv_rdata = nv_read ? store_q : ~store_q;
    assign nv_busy  = busy_req;
    assign nv_fail  = fail_req & nv_write;
endmodule
`default_nettype wire
